// ==== branch_incr_or_shift_exec.v ====
// Executor for the jump, increment, inclusive OR and left shift instructions.
//
// Contract
// - Jump loads 11-bit immediate into PC low
// - Jump takes PC top from latch bits
// - Jump takes two instruction cycles
// - Destination bit picks accumulator or register
// - Bump instructions add one to register
// - Zero bump-skip result skips next, two cycles
// - Literal OR into accumulator, null updated
// - Accumulator OR register to destination, null
// - Left shift, bit 7 out, zero in
`include "exec_map.vh"
module branch_incr_or_shift_exec #(
    parameter CLK_PER_CYCLE = `CLK_PER_INSN_CYCLE
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Write address channel.
    input wire [4:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // Write data channel.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // Write response channel.
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel.
    input wire [4:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // Read data channel.
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////////
    // Core state.

    // Accumulator, upper address latch and program counter.
    reg [7:0] acc_r;
    reg [6:0] latch_r;
    reg [14:0] pc_r;
    // Null result and shift-out flags.
    reg null_r;
    reg shift_r;
    // Instruction held for execution and its progress.
    reg [31:0] insn_r;
    reg busy_r;
    reg started_r;
    reg skip_r;
    // File register address pointer for software access.
    reg [6:0] faddr_r;
    // Count of instruction cycles spent executing.
    reg [31:0] cycles_r;
    // File registers, one byte each.
    wire [7:0] file_q [0:127];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave state.

    // Held write address and data, either may arrive first.
    reg aw_held_r;
    reg w_held_r;
    reg [4:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    // Response registers.
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;

    // A write is performed once both halves are held and no response waits.
    wire do_write;
    assign do_write = aw_held_r & w_held_r & ~bvalid_r;
    // A read is taken whenever no read answer is outstanding.
    wire do_read;
    assign do_read = s_axi_arvalid & ~rvalid_r;

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Replace only the byte lanes whose strobe is set.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] wmerged_acc;
    wire [31:0] wmerged_latch;
    wire [31:0] wmerged_pc;
    wire [31:0] wmerged_faddr;
    wire [31:0] wmerged_fdata;
    wire [31:0] wmerged_status;
    wire [31:0] wmerged_insn;
    assign wmerged_acc = merge({24'h000000, acc_r}, wdata_r, wstrb_r);
    assign wmerged_latch = merge({25'h0000000, latch_r}, wdata_r, wstrb_r);
    assign wmerged_pc = merge({17'h00000, pc_r}, wdata_r, wstrb_r);
    assign wmerged_faddr = merge({25'h0000000, faddr_r}, wdata_r, wstrb_r);
    assign wmerged_fdata = merge({24'h000000, file_q[faddr_r]}, wdata_r, wstrb_r);
    assign wmerged_status = merge({30'h00000000, shift_r, null_r}, wdata_r, wstrb_r);
    assign wmerged_insn = merge(insn_r, wdata_r, wstrb_r);

    // Decoded software writes per register.
    wire sw_insn;
    wire sw_acc;
    wire sw_latch;
    wire sw_status;
    wire sw_pc;
    wire sw_faddr;
    wire sw_fdata;
    assign sw_insn = do_write & (awaddr_r == `OFS_INSN) & ~busy_r;
    assign sw_acc = do_write & (awaddr_r == `OFS_ACC);
    assign sw_latch = do_write & (awaddr_r == `OFS_LATCH);
    assign sw_status = do_write & (awaddr_r == `OFS_STATUS);
    assign sw_pc = do_write & (awaddr_r == `OFS_PC);
    assign sw_faddr = do_write & (awaddr_r == `OFS_FADDR);
    assign sw_fdata = do_write & (awaddr_r == `OFS_FDATA);

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction cycle pacing and evaluation.

    wire tick;
    insn_pacer #(
        .DIV(CLK_PER_CYCLE)
    ) u_pacer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    wire [7:0] alu_result;
    wire alu_wr_acc;
    wire alu_wr_file;
    wire alu_upd_null;
    wire alu_upd_shift;
    wire alu_shift_out;
    wire [14:0] alu_pc_next;
    wire alu_skip;
    wire alu_two;
    wire [6:0] op_faddr;
    assign op_faddr = insn_r[`INSN_F_HI:0];

    insn_alu u_alu (
        .op(insn_r[`INSN_OP_HI:`INSN_OP_LO]),
        .dest(insn_r[`INSN_DEST_BIT]),
        .operand(insn_r[`INSN_K11_HI:0]),
        .acc(acc_r),
        .fval(file_q[op_faddr]),
        .latch(latch_r),
        .pc(pc_r),
        .result(alu_result),
        .wr_acc(alu_wr_acc),
        .wr_file(alu_wr_file),
        .upd_null(alu_upd_null),
        .upd_shift(alu_upd_shift),
        .shift_out(alu_shift_out),
        .pc_next(alu_pc_next),
        .skip(alu_skip),
        .two_cycle(alu_two)
    );

    // The first instruction cycle of a busy instruction commits all results.
    wire commit;
    assign commit = busy_r & tick & ~started_r;

    ////////////////////////////////////////////////////////////////////////////////
    // File registers.

    // Execution writes win over a software write in the same clock.
    genvar g;
    generate
        for (g = 0; g < 128; g = g + 1) begin : g_file
            reg [7:0] byte_r;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    byte_r <= `RST_BYTE;
                end else if (commit && alu_wr_file && op_faddr == g) begin
                    byte_r <= alu_result;
                end else if (sw_fdata && faddr_r == g) begin
                    byte_r <= wmerged_fdata[7:0];
                end
            end
            assign file_q[g] = byte_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Execution sequencing and core registers.

    // Launch on a write to the instruction register, commit on the next
    // instruction cycle, and stay busy one more cycle for two-cycle forms.
    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= `RST_BYTE;
            latch_r <= 7'h00;
            pc_r <= `RST_PC;
            null_r <= 1'b0;
            shift_r <= 1'b0;
            insn_r <= 32'h00000000;
            busy_r <= 1'b0;
            started_r <= 1'b0;
            skip_r <= 1'b0;
            faddr_r <= 7'h00;
            cycles_r <= 32'h00000000;
        end else begin
            if (sw_latch) begin
                latch_r <= wmerged_latch[6:0];
            end
            if (sw_faddr) begin
                faddr_r <= wmerged_faddr[6:0];
            end
            if (sw_insn) begin
                insn_r <= wmerged_insn;
                busy_r <= 1'b1;
                started_r <= 1'b0;
            end
            if (busy_r && tick) begin
                cycles_r <= cycles_r + 32'h00000001;
            end
            if (commit) begin
                started_r <= 1'b1;
                skip_r <= alu_skip;
                if (!alu_two) begin
                    busy_r <= 1'b0;
                end
                pc_r <= alu_pc_next;
                if (alu_wr_acc) begin
                    acc_r <= alu_result;
                end else if (sw_acc) begin
                    acc_r <= wmerged_acc[7:0];
                end
                if (alu_upd_null) begin
                    null_r <= (alu_result == 8'h00);
                end else if (sw_status) begin
                    null_r <= wmerged_status[`ST_NULL];
                end
                if (alu_upd_shift) begin
                    shift_r <= alu_shift_out;
                end else if (sw_status) begin
                    shift_r <= wmerged_status[`ST_SHIFT];
                end
            end else begin
                if (busy_r && tick) begin
                    // second cycle of jump or skip ends here
                    busy_r <= 1'b0;
                end
                if (sw_pc) begin
                    pc_r <= wmerged_pc[14:0];
                end
                if (sw_acc) begin
                    acc_r <= wmerged_acc[7:0];
                end
                if (sw_status) begin
                    null_r <= wmerged_status[`ST_NULL];
                    shift_r <= wmerged_status[`ST_SHIFT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path.

    // Hold each half until the pair can be written; a write to the instruction
    // register while busy is answered with an error and has no effect.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 5'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                if (awaddr_r == `OFS_CYCLES || (awaddr_r == `OFS_INSN && busy_r)) begin
                    bresp_r <= `RESP_SLVERR;
                end else begin
                    bresp_r <= `RESP_OKAY;
                end
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path.

    // Reads answer one clock after the address is taken; all offsets in the
    // 32-byte window are mapped, so no read is refused.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            case ({s_axi_araddr[4:2], 2'b00})
                `OFS_INSN: rdata_r <= insn_r;
                `OFS_ACC: rdata_r <= {24'h000000, acc_r};
                `OFS_LATCH: rdata_r <= {25'h0000000, latch_r};
                `OFS_STATUS: rdata_r <= {28'h0000000, skip_r, busy_r, shift_r, null_r};
                `OFS_PC: rdata_r <= {17'h00000, pc_r};
                `OFS_FADDR: rdata_r <= {25'h0000000, faddr_r};
                `OFS_FDATA: rdata_r <= {24'h000000, file_q[faddr_r]};
                default: rdata_r <= cycles_r;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// ==== exec_map.vh ====
// Register offsets, field positions, opcodes and timing counts for the executor.
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// Register byte offsets on the AXI4-Lite bus.
`define OFS_INSN 5'h00
`define OFS_ACC 5'h04
`define OFS_LATCH 5'h08
`define OFS_STATUS 5'h0c
`define OFS_PC 5'h10
`define OFS_FADDR 5'h14
`define OFS_FDATA 5'h18
`define OFS_CYCLES 5'h1c

// Instruction word fields.
`define INSN_OP_HI 18
`define INSN_OP_LO 16
`define INSN_DEST_BIT 15
`define INSN_K11_HI 10
`define INSN_K8_HI 7
`define INSN_F_HI 6

// Status register bit positions.
`define ST_NULL 0
`define ST_SHIFT 1
`define ST_BUSY 2
`define ST_SKIP 3

// Opcodes.
`define OP_NONE 3'h0
`define OP_JUMP 3'h1
`define OP_BUMP 3'h2
`define OP_BUMP_SKIP 3'h3
`define OP_OR_LIT 3'h4
`define OP_OR_REG 3'h5
`define OP_SHIFT_LEFT 3'h6

// Clocks per instruction cycle and reset values.
`define CLK_PER_INSN_CYCLE 4
`define RST_BYTE 8'h00
`define RST_PC 15'h0000

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== insn_pacer.v ====
// Divider that marks one clock in each instruction cycle.
`include "exec_map.vh"
module insn_pacer #(
    parameter DIV = `CLK_PER_INSN_CYCLE
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // One-cycle pulse per instruction cycle.
    output reg tick
);
    // Phase counter within the instruction cycle.
    reg [7:0] phase_r;

    // Free-running count; the pulse is high in the clock after the last phase.
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 8'h00;
            tick <= 1'b0;
        end else if (phase_r == DIV[7:0] - 8'h01) begin
            phase_r <= 8'h00;
            tick <= 1'b1;
        end else begin
            phase_r <= phase_r + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

// ==== insn_alu.v ====
// Combinational result, flag and program counter logic for one instruction.
`include "exec_map.vh"
module insn_alu (
    // Decoded instruction.
    input wire [2:0] op,
    input wire dest,
    input wire [10:0] operand,
    // Current core state.
    input wire [7:0] acc,
    input wire [7:0] fval,
    input wire [6:0] latch,
    input wire [14:0] pc,
    // Result and where it goes.
    output reg [7:0] result,
    output reg wr_acc,
    output reg wr_file,
    // Flag updates.
    output reg upd_null,
    output reg upd_shift,
    output reg shift_out,
    // Program counter and timing.
    output reg [14:0] pc_next,
    output reg skip,
    output reg two_cycle
);
    // Decode one instruction; unknown codes act as one-cycle no-ops.
    always @* begin
        result = 8'h00;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_null = 1'b0;
        upd_shift = 1'b0;
        shift_out = 1'b0;
        skip = 1'b0;
        two_cycle = 1'b0;
        pc_next = pc + 15'h0001;
        case (op)
            `OP_JUMP: begin
                pc_next = {latch[6:3], operand};
                two_cycle = 1'b1;
            end
            `OP_BUMP, `OP_BUMP_SKIP: begin
                result = fval + 8'h01;
                wr_acc = ~dest;
                wr_file = dest;
                upd_null = (op == `OP_BUMP);
                if (op == `OP_BUMP_SKIP && result == 8'h00) begin
                    skip = 1'b1;
                    two_cycle = 1'b1;
                    pc_next = pc + 15'h0002;
                end
            end
            `OP_OR_LIT: begin
                result = acc | operand[7:0];
                wr_acc = 1'b1;
                upd_null = 1'b1;
            end
            `OP_OR_REG: begin
                result = acc | fval;
                wr_acc = ~dest;
                wr_file = dest;
                upd_null = 1'b1;
            end
            `OP_SHIFT_LEFT: begin
                result = {fval[6:0], 1'b0};
                shift_out = fval[7];
                upd_shift = 1'b1;
                upd_null = 1'b1;
                wr_acc = ~dest;
                wr_file = dest;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end
endmodule

// ==== exec_monitor.sv ====
// Checker for the executor's bus handshakes, bound to its top module.
`include "exec_map.vh"
module exec_monitor (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Write channels.
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels.
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are given once for every property.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    // A new read address is refused exactly while a read answer is pending.
    ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready does not track rvalid");
    // The read answer comes exactly one edge after the address is taken.
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // A stalled read answer keeps its data.
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    rd_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == `RESP_OKAY)
        else $error("read response not okay");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    // Halves taken on one edge give a response two edges later.
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write response late");
    addr_held_a: assert property (s_axi_awvalid && s_axi_awready && !s_axi_bvalid |=> !s_axi_awready)
        else $error("held address not blocking");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    // Leaving reset, nothing is pending and reads are accepted.
    reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
        else $error("bus not idle after reset");
    ////////////////////////////////////////////////////////////////////////////
    refused_c: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
    rd_stall_c: cover property (s_axi_rvalid && !s_axi_rready);
    wr_stall_c: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind branch_incr_or_shift_exec exec_monitor u_exec_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// ==== prog_store.sv ====
// Program store that hands out one instruction template for each slot.
`include "exec_map.vh"
module prog_store (
    // Slot to fetch.
    input wire [2:0] idx,
    // Opcode field only; the bench fills destination and operand bits.
    output logic [31:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] op;
    // Slots are shuffled so neighbouring fetches differ in kind.
    always_comb begin
        case (idx)
            3'h0: op = `OP_JUMP;
            3'h1: op = `OP_BUMP_SKIP;
            3'h2: op = `OP_OR_LIT;
            3'h3: op = `OP_BUMP;
            3'h4: op = `OP_SHIFT_LEFT;
            3'h5: op = `OP_OR_REG;
            3'h6: op = `OP_NONE;
            default: op = 3'h7;
        endcase
    end
    assign word = {13'h0, op, 16'h0};
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the executor, driven over its register bus.
`include "exec_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat, w, seed = 32'h000126df;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, skp, two, m_null, m_shift, d;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] idx = 3'h0, op;
    logic [7:0] acc, fv, r;
    logic [6:0] fa, m_latch;
    logic [14:0] m_pc;
    logic [31:0] m_cyc = 32'h0, word;
    note_t r_q[$];
    note_t note;
    logic [1:0] b_q[$];
    int n_mismatch = 0, checked = 0, i, k;
    branch_incr_or_shift_exec #(.CLK_PER_CYCLE(8)) u_branch_incr_or_shift_exec (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    prog_store u_prog_store (.idx(idx), .word(word));
    initial begin
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic give_up();
        n_mismatch++;
        $display("ERROR handshake expected within bound seen none");
        complete_run();
    endtask
    // Write with both halves offered together; bready may lag by up to two cycles.
    task automatic wr(input logic [4:0] a, input logic [31:0] dat, input logic [1:0] er);
        int n, dly;
        logic aw_hs, w_hs, b_hs;
        dly = rnd() % 3;
        b_q.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (dly == 0);
        b_hs = 1'b0;
        for (n = 0; n < 200 && !b_hs; n++) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (n + 1 == dly) s_axi_bready <= 1'b1;
        end
        if (!b_hs) give_up();
    endtask
    // Read; the note is compared under mask m, and a zero mask only polls.
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string nm, output logic [31:0] got);
        int n, dly;
        logic ar_hs, r_hs;
        dly = rnd() % 3;
        r_q.push_back('{nm, e, m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (dly == 0);
        r_hs = 1'b0;
        for (n = 0; n < 200 && !r_hs; n++) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            got = s_axi_rdata;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (n + 1 == dly) s_axi_rready <= 1'b1;
        end
        if (!r_hs) give_up();
    endtask
    task automatic wait_idle();
        rdat = 32'h4;
        for (k = 0; k < 50 && rdat[`ST_BUSY]; k++) rd(`OFS_STATUS, 0, 0, "busy", rdat);
        if (rdat[`ST_BUSY]) give_up();
    endtask
    // Results are compared where the handshake shows them, oldest note first.
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && r_q.size() > 0) begin
            note = r_q.pop_front();
            if (note.m != 0) check(note.nm, note.e & note.m, s_axi_rdata & note.m);
        end
        if (s_axi_bvalid && s_axi_bready && b_q.size() > 0)
            check("bresp", {30'h0, b_q.pop_front()}, {30'h0, s_axi_bresp});
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 8; i++) rd(5'(i * 4), 0, 32'hffffffff, "reset", rdat);
        $display("test reset done");
        for (i = 0; i < 48; i++) begin
            idx <= i[2:0];
            {m_latch, fv, acc, skp, fa} = rnd();
            w = rnd();
            // Force all-ones for two batches (i 8 to 15 and 40 to 47) so bump_skip_if_null surely wraps.
            if (w[1:0] == 2'h0 || i[4:3] == 2'b01) fv = 8'hff;
            else if (w[3:2] == 2'h0) {acc, fv, fa, w[31:28]} = 0;
            {m_null, m_shift, m_pc} = w[22:6];
            wr(`OFS_LATCH, {25'h0, m_latch}, `RESP_OKAY);
            wr(`OFS_PC, {17'h0, m_pc}, `RESP_OKAY);
            wr(`OFS_ACC, {24'h0, acc}, `RESP_OKAY);
            wr(`OFS_STATUS, {30'h0, m_shift, m_null}, `RESP_OKAY);
            wr(`OFS_FADDR, {25'h0, fa}, `RESP_OKAY);
            wr(`OFS_FDATA, {24'h0, fv}, `RESP_OKAY);
            w = word | {16'h0, w[7], 4'h0, w[31:28], fa};
            wr(`OFS_INSN, w, `RESP_OKAY);
            wait_idle();
            {op, d, r, two, skp} = {w[18:15], 10'h0};
            case (op)
                `OP_JUMP: {m_pc, two} = {m_latch[6:3], w[10:0], 1'b1};
                `OP_BUMP, `OP_BUMP_SKIP: r = fv + 8'h01;
                `OP_OR_LIT: r = acc | w[7:0];
                `OP_OR_REG: r = acc | fv;
                `OP_SHIFT_LEFT: {m_shift, r} = {fv, 1'b0};
                default: ;
            endcase
            if (op == `OP_BUMP_SKIP) {skp, two} = {2{r == 8'h00}};
            else if (op >= `OP_BUMP && op <= `OP_SHIFT_LEFT) m_null = (r == 8'h00);
            if (op == `OP_OR_LIT || (!d && op >= `OP_BUMP && op <= `OP_SHIFT_LEFT)) acc = r;
            else if (op >= `OP_BUMP && op <= `OP_SHIFT_LEFT) fv = r;
            if (op != `OP_JUMP) m_pc = m_pc + 15'h0001 + {14'h0, skp};
            m_cyc = m_cyc + 32'h1 + {31'h0, two};
            rd(`OFS_ACC, {24'h0, acc}, 32'hff, "acc", rdat);
            rd(`OFS_FDATA, {24'h0, fv}, 32'hff, "file", rdat);
            rd(`OFS_STATUS, {28'h0, skp, 1'b0, m_shift, m_null}, 32'hf, "status", rdat);
            rd(`OFS_PC, {17'h0, m_pc}, 32'h7fff, "pc", rdat);
            rd(`OFS_CYCLES, m_cyc, 32'hffffffff, "cycles", rdat);
        end
        $display("test execute done");
        wr(`OFS_CYCLES, 32'h5a, `RESP_SLVERR);
        rd(`OFS_CYCLES, m_cyc, 32'hffffffff, "cycles", rdat);
        // A second instruction while the jump is still running must be refused.
        wr(`OFS_INSN, {13'h0, `OP_JUMP, 5'h0, 11'h155}, `RESP_OKAY);
        wr(`OFS_INSN, {13'h0, `OP_JUMP, 5'h0, 11'h2aa}, `RESP_SLVERR);
        wait_idle();
        rd(`OFS_PC, {17'h0, m_latch[6:3], 11'h155}, 32'h7fff, "pc", rdat);
        rd(`OFS_CYCLES, m_cyc + 32'h2, 32'hffffffff, "cycles", rdat);
        $display("test refusal done");
        complete_run();
    end
endmodule
